//--- src/serial_mem_device.sv
// serial memory engine: command decode, array, self-timed programming
// assumes pins are synchronous to clk; reset_n stands for power-on
// Operation
// RULE1: host waits powerup delay before commands
// RULE2: nine bits x16, ten bits x8
// RULE3: input bits captured on serial clock rise
// RULE4: output floats except read or status
// RULE5: select during programming shows busy/ready
// RULE6: a one shifted in floats status
// RULE7: status may only be floated when ready
// RULE8: start, opcode, address, data order
// RULE9: 10 read, 11 erase, 01 write
// RULE10: opcode 00 special by top address bits
// RULE11: read sends dummy zero then msb first
// RULE12: read bits change on clock rise
// RULE13: sequential read increments and wraps
// RULE14: starts write-disabled until enable command
// RULE15: reads work regardless of enable
// RULE16: select fall starts the programming cycle
// RULE17: programming needs no further serial clocks
// RULE18: write auto-clears before storing
// RULE19: erase sets addressed word all ones
// RULE20: clear-all sets every bit one
// RULE21: fill-all stores word everywhere
// RULE22: strap high x16, low x8
// RULE23: status valid within 0.25 us
// RULE24: busy device ignores new commands
`timescale 1ns/1ns
`include "serial_mem_defs.svh"
module serial_mem_device
    import serial_mem_pkg::*;
#(
    parameter int PROGRAM_CYCLES = `PROGRAM_CYC
)
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic word_width_strap,
    serial_mem_if.mem link
);
    initial
    begin
        // the cycle counter is 23 bits wide
        if (PROGRAM_CYCLES < 1 || PROGRAM_CYCLES >= 32'h0080_0000)
            $error("PROGRAM_CYCLES out of range");
    end

    // ************************************************************
    // pin edges
    // ************************************************************
    logic sclk_q;
    logic cs_q;
    logic wide_q;
    wire sclk_rise = link.serial_clock_in & ~sclk_q; // RULE3 RULE12
    wire cs_rise = ~cs_q & link.chip_select;

    // ************************************************************
    // state and storage
    // ************************************************************
    typedef enum {ST_IDLE, ST_HEAD, ST_DATA, ST_READ, ST_ARMED,
                  ST_IGNORE, ST_PROG} dev_state_t;
    dev_state_t state_q;
    logic [7:0] byte_q [0:127];
    logic [9:0] head_q;
    logic [3:0] head_cnt_q;
    logic [15:0] data_q;
    logic [4:0] data_cnt_q;
    logic [6:0] addr_q;
    logic [15:0] out_q;
    logic [4:0] out_cnt_q;
    logic enable_q;
    logic status_on_q;
    logic do_q;
    logic do_en_q;
    mem_cmd_t cmd_q;
    logic [22:0] prog_cnt_q;

    // RULE22 RULE2 RULE8
    wire [3:0] head_len = wide_q ? 4'd8 : 4'd9;
    wire [4:0] word_len = wide_q ? 5'd16 : 5'd8;
    wire [9:0] head_next = {head_q[8:0], link.serial_in};
    wire [1:0] opc = wide_q ? head_next[7:6] : head_next[8:7];
    wire [1:0] sub = wide_q ? head_next[5:4] : head_next[6:5];
    wire [6:0] addr_in = wide_q ? {1'b0, head_next[5:0]} : head_next[6:0];
    wire [6:0] addr_max = wide_q ? 7'h3F : 7'h7F;
    wire [6:0] addr_inc = (addr_q == addr_max) ? 7'h00 : addr_q + 7'd1;
    wire [15:0] word_at = wide_q ?
        {byte_q[{addr_q[5:0], 1'b1}], byte_q[{addr_q[5:0], 1'b0}]} :
        {byte_q[addr_q], 8'h00};
    wire [15:0] data_next = {data_q[14:0], link.serial_in};

    mem_cmd_t cmd_dec;
    always_comb
    begin
        cmd_dec = CMD_READ;
        case (opc)
            `OP_READ: cmd_dec = CMD_READ; // RULE9
            `OP_WRITE: cmd_dec = CMD_WRITE;
            `OP_ERASE: cmd_dec = CMD_ERASE;
            default:
                case (sub) // RULE10
                    `SP_ENABLE: cmd_dec = CMD_ENABLE;
                    `SP_DISABLE: cmd_dec = CMD_DISABLE;
                    `SP_CLEAR: cmd_dec = CMD_CLEAR_ALL;
                    default: cmd_dec = CMD_FILL_ALL;
                endcase
        endcase
    end
    wire needs_data = (cmd_dec == CMD_WRITE) || (cmd_dec == CMD_FILL_ALL);

    // ************************************************************
    // engine
    // ************************************************************
    always_ff @(posedge clk)
    begin
        sclk_q <= link.serial_clock_in;
        cs_q <= link.chip_select;
        if (!reset_n)
        begin
            wide_q <= 1'b1;
            state_q <= ST_IDLE;
            head_q <= '0;
            head_cnt_q <= '0;
            data_q <= '0;
            data_cnt_q <= '0;
            addr_q <= '0;
            out_q <= '0;
            out_cnt_q <= '0;
            enable_q <= 1'b0; // RULE14
            status_on_q <= 1'b0;
            do_q <= 1'b0;
            do_en_q <= 1'b0;
            cmd_q <= CMD_READ;
            prog_cnt_q <= '0;
        end
        else
        begin
            if (state_q == ST_IDLE && !link.chip_select)
                wide_q <= word_width_strap; // RULE22
            case (state_q)
                ST_IDLE:
                    if (link.chip_select && sclk_rise && link.serial_in)
                    begin
                        state_q <= ST_HEAD;
                        head_q <= '0;
                        head_cnt_q <= '0;
                    end
                ST_HEAD:
                    if (!link.chip_select)
                        state_q <= ST_IDLE;
                    else if (sclk_rise)
                    begin
                        head_q <= head_next;
                        head_cnt_q <= head_cnt_q + 4'd1;
                        if (head_cnt_q + 4'd1 == head_len)
                        begin
                            cmd_q <= cmd_dec;
                            addr_q <= addr_in;
                            data_cnt_q <= '0;
                            if (needs_data)
                                state_q <= ST_DATA;
                            else if (cmd_dec == CMD_READ)
                            begin
                                state_q <= ST_READ; // RULE15
                                do_q <= 1'b0; // RULE11
                                do_en_q <= 1'b1;
                                out_cnt_q <= '0;
                            end
                            else if (cmd_dec == CMD_ENABLE)
                            begin
                                enable_q <= 1'b1;
                                state_q <= ST_IGNORE;
                            end
                            else if (cmd_dec == CMD_DISABLE)
                            begin
                                enable_q <= 1'b0;
                                state_q <= ST_IGNORE;
                            end
                            else
                                state_q <= ST_ARMED;
                        end
                    end
                ST_DATA:
                    if (!link.chip_select)
                        state_q <= ST_IDLE;
                    else if (sclk_rise)
                    begin
                        data_q <= data_next;
                        data_cnt_q <= data_cnt_q + 5'd1;
                        if (data_cnt_q + 5'd1 == word_len)
                            state_q <= ST_ARMED;
                    end
                ST_READ:
                    if (!link.chip_select)
                    begin
                        state_q <= ST_IDLE;
                        do_en_q <= 1'b0; // RULE4
                    end
                    else if (sclk_rise)
                    begin
                        // RULE12 RULE13
                        if (out_cnt_q == 5'd0)
                        begin
                            do_q <= word_at[15];
                            out_q <= {word_at[14:0], 1'b0};
                            out_cnt_q <= word_len - 5'd1;
                            addr_q <= addr_inc;
                        end
                        else
                        begin
                            do_q <= out_q[15];
                            out_q <= {out_q[14:0], 1'b0};
                            out_cnt_q <= out_cnt_q - 5'd1;
                        end
                    end
                ST_ARMED:
                    if (!link.chip_select)
                    begin
                        // RULE16 RULE14
                        state_q <= enable_q ? ST_PROG : ST_IDLE;
                        prog_cnt_q <= '0;
                    end
                ST_IGNORE:
                    if (!link.chip_select)
                        state_q <= ST_IDLE;
                ST_PROG:
                begin
                    // RULE17 RULE24
                    prog_cnt_q <= prog_cnt_q + 23'd1;
                    if (cs_rise)
                        status_on_q <= 1'b1;
                    if (!link.chip_select)
                        status_on_q <= 1'b0;
                    if (prog_cnt_q + 23'd1 >= 23'(PROGRAM_CYCLES))
                    begin
                        state_q <= ST_IDLE;
                        status_on_q <= 1'b0;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
            // RULE5 RULE23 RULE6 RULE7
            if (state_q == ST_PROG)
            begin
                // a one clocked in cannot float busy status
                do_en_q <= (status_on_q | cs_rise) & link.chip_select;
                do_q <= 1'b0;
            end
            else if (state_q == ST_IDLE)
            begin
                // ready stands until deselect or a one clocked in;
                // head and read states own the pin themselves
                do_en_q <= do_en_q & do_q & link.chip_select &
                           ~(sclk_rise & link.serial_in);
            end
            if (state_q == ST_PROG && prog_cnt_q + 23'd1 >=
                23'(PROGRAM_CYCLES) && link.chip_select && do_en_q)
                do_q <= 1'b1; // RULE5
        end
    end

    // ************************************************************
    // array update at the end of the self-timed cycle
    // ************************************************************
    wire prog_done = (state_q == ST_PROG) &&
                     (prog_cnt_q + 23'd1 >= 23'(PROGRAM_CYCLES));
    always_ff @(posedge clk)
    begin
        for (int i = 0; i < 128; i++)
        begin
            // array is nonvolatile; reset leaves it alone
            if (prog_done)
            begin
                if (cmd_q == CMD_CLEAR_ALL)
                    byte_q[i] <= 8'hFF; // RULE20
                else if (cmd_q == CMD_FILL_ALL)
                    byte_q[i] <= wide_q ? (i[0] ? data_q[15:8] : data_q[7:0])
                                        : data_q[7:0]; // RULE21
                else if (wide_q && i[6:1] == addr_q[5:0])
                    byte_q[i] <= (cmd_q == CMD_ERASE) ? 8'hFF :
                        (i[0] ? data_q[15:8] : data_q[7:0]); // RULE18 RULE19
                else if (!wide_q && 7'(i) == addr_q)
                    byte_q[i] <= (cmd_q == CMD_ERASE) ? 8'hFF : data_q[7:0];
            end
        end
    end

    assign link.data_out = do_q;
    assign link.data_out_en = do_en_q;
endmodule

//--- src/serial_mem_defs.svh
// timing counts and command field codes for the serial memory link
// assumes a 20 MHz system clock shared by both ends
`ifndef SERIAL_MEM_DEFS_SVH
`define SERIAL_MEM_DEFS_SVH

`define CLK_PERIOD_NS 50
// select_low_min_time in ns, rounded up to cycles
`define SELECT_LOW_MIN_NS 250
`define SELECT_LOW_MIN_CYC ((`SELECT_LOW_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// status valid after select, ns, rounded down
`define STATUS_VALID_NS 250
`define STATUS_VALID_CYC (`STATUS_VALID_NS / `CLK_PERIOD_NS)
// program pulse width in us
`define PROGRAM_TIME_US 5000
`define PROGRAM_CYC (`PROGRAM_TIME_US * 1000 / `CLK_PERIOD_NS)
// powerup_to_read_delay / powerup_to_program_delay in us
`define POWERUP_DELAY_US 1000
`define POWERUP_CYC (`POWERUP_DELAY_US * 1000 / `CLK_PERIOD_NS)
// serial clock half period in system cycles (2 MHz max -> 5)
`define SCLK_HALF_CYC 5

`define OP_SPECIAL 2'b00
`define OP_WRITE 2'b01
`define OP_READ 2'b10
`define OP_ERASE 2'b11
`define SP_DISABLE 2'b00
`define SP_FILL 2'b01
`define SP_CLEAR 2'b10
`define SP_ENABLE 2'b11

`endif

//--- src/serial_mem_pkg.sv
// types shared by both ends of the serial memory link
package serial_mem_pkg;
    typedef enum logic [2:0] {
        CMD_READ,
        CMD_WRITE,
        CMD_ERASE,
        CMD_ENABLE,
        CMD_DISABLE,
        CMD_CLEAR_ALL,
        CMD_FILL_ALL
    } mem_cmd_t;
endpackage

//--- src/serial_mem_if.sv
// pins between the memory and its host; the serial output is three-state
// assumes the bench resolves the pin level from data_out_en
`timescale 1ns/1ns
interface serial_mem_if;
    logic chip_select;
    logic serial_clock_in;
    logic serial_in;
    logic data_out;
    logic data_out_en;
    modport mem
    (
        input chip_select,
        input serial_clock_in,
        input serial_in,
        output data_out,
        output data_out_en
    );
    modport host
    (
        output chip_select,
        output serial_clock_in,
        output serial_in,
        input data_out,
        input data_out_en
    );
endinterface

//--- src/serial_mem_host.sv
// host end: turns one command request into serial pin activity
// assumes the memory end shares clk; one request at a time
`timescale 1ns/1ns
`include "serial_mem_defs.svh"
module serial_mem_host
    import serial_mem_pkg::*;
#(
    parameter int POWERUP_CYCLES = `POWERUP_CYC
)
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic wide_mode,
    input wire logic req_valid,
    input wire mem_cmd_t req_cmd,
    input wire logic [6:0] req_addr,
    input wire logic [15:0] req_data,
    output logic req_ready,
    output logic rsp_valid,
    output logic [15:0] rsp_data,
    serial_mem_if.host link
);
    initial
    begin
        // the power-up counter is 21 bits wide
        if (POWERUP_CYCLES < 1 || POWERUP_CYCLES >= 32'h0020_0000)
            $error("POWERUP_CYCLES out of range");
    end

    typedef enum {H_WAIT, H_IDLE, H_SHIFT, H_READ, H_GAP, H_POLL}
        host_state_t;
    host_state_t state_q;
    logic [20:0] wait_q;
    logic [2:0] div_q;
    logic [26:0] sh_q;
    logic [4:0] cnt_q;
    logic [15:0] rd_q;
    logic prog_q;
    logic is_rd_q;
    logic wen_q;
    logic cs_q;
    logic sk_q;
    logic di_q;

    wire tick = (div_q == 3'(`SCLK_HALF_CYC - 1));
    // a floating output pin reads low
    wire dout_seen = link.data_out_en & link.data_out;
    wire [1:0] opc = (req_cmd == CMD_READ) ? `OP_READ :
                     (req_cmd == CMD_WRITE) ? `OP_WRITE :
                     (req_cmd == CMD_ERASE) ? `OP_ERASE : `OP_SPECIAL;
    wire [1:0] sub = (req_cmd == CMD_ENABLE) ? `SP_ENABLE :
                     (req_cmd == CMD_CLEAR_ALL) ? `SP_CLEAR :
                     (req_cmd == CMD_FILL_ALL) ? `SP_FILL : `SP_DISABLE;
    wire [6:0] a = (opc == `OP_SPECIAL) ? {sub, 5'h00} :
                   (wide_mode ? {req_addr[5:0], 1'b0} : req_addr);
    wire with_data = (req_cmd == CMD_WRITE) || (req_cmd == CMD_FILL_ALL);
    // RULE2 RULE8: frame left-aligned, start bit first
    wire [26:0] frame = wide_mode ? {1'b1, opc, a[6:1], req_data, 2'b00}
                                  : {1'b1, opc, a, req_data[7:0], 9'h000};
    wire [4:0] bits = (wide_mode ? 5'd9 : 5'd10) +
                      (with_data ? (wide_mode ? 5'd16 : 5'd8) : 5'd0);

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            state_q <= H_WAIT;
            wait_q <= '0;
            div_q <= '0;
            sh_q <= '0;
            cnt_q <= '0;
            rd_q <= '0;
            prog_q <= 1'b0;
            is_rd_q <= 1'b0;
            wen_q <= 1'b0;
            cs_q <= 1'b0;
            sk_q <= 1'b0;
            di_q <= 1'b0;
            req_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_data <= '0;
        end
        else
        begin
            rsp_valid <= 1'b0;
            div_q <= tick ? 3'd0 : div_q + 3'd1;
            case (state_q)
                H_WAIT:
                begin
                    wait_q <= wait_q + 21'd1;
                    if (wait_q + 21'd1 >= 21'(POWERUP_CYCLES))
                    begin
                        state_q <= H_IDLE; // RULE1
                        req_ready <= 1'b1;
                    end
                end
                H_IDLE:
                    if (req_valid)
                    begin
                        req_ready <= 1'b0;
                        di_q <= frame[26];
                        sh_q <= {frame[25:0], 1'b0};
                        cnt_q <= bits;
                        is_rd_q <= (opc == `OP_READ);
                        if (req_cmd == CMD_ENABLE)
                            wen_q <= 1'b1;
                        else if (req_cmd == CMD_DISABLE)
                            wen_q <= 1'b0;
                        // RULE14: a refused command starts no cycle to poll
                        prog_q <= wen_q && (opc != `OP_READ) &&
                            (opc != `OP_SPECIAL || sub == `SP_CLEAR ||
                            sub == `SP_FILL);
                        cs_q <= 1'b1;
                        // first bit gets a full half period of setup
                        div_q <= '0;
                        state_q <= H_SHIFT;
                    end
                H_SHIFT, H_READ:
                    if (tick)
                    begin
                        sk_q <= ~sk_q;
                        if (sk_q)
                        begin
                            cnt_q <= cnt_q - 5'd1;
                            // RULE3: data moves on the falling clock
                            if (state_q == H_SHIFT)
                            begin
                                di_q <= sh_q[26];
                                sh_q <= {sh_q[25:0], 1'b0};
                            end
                            if (state_q == H_READ)
                                rd_q <= {rd_q[14:0], dout_seen};
                            if (cnt_q == 5'd1 && state_q == H_SHIFT &&
                                is_rd_q)
                            begin
                                // dummy bit went by on this fall
                                state_q <= H_READ; // RULE11
                                di_q <= 1'b0;
                                cnt_q <= wide_mode ? 5'd16 : 5'd8;
                            end
                            else if (cnt_q == 5'd1)
                            begin
                                cs_q <= 1'b0; // RULE16
                                di_q <= 1'b0;
                                cnt_q <= 5'(`SELECT_LOW_MIN_CYC);
                                state_q <= H_GAP;
                            end
                        end
                    end
                H_GAP:
                begin
                    cnt_q <= cnt_q - 5'd1;
                    if (cnt_q == 5'd1)
                    begin
                        if (prog_q)
                        begin
                            cs_q <= 1'b1; // RULE5
                            cnt_q <= 5'(`STATUS_VALID_CYC + 1);
                            state_q <= H_POLL;
                        end
                        else
                        begin
                            rsp_valid <= is_rd_q;
                            rsp_data <= wide_mode ? rd_q : {8'h00, rd_q[7:0]};
                            req_ready <= 1'b1;
                            state_q <= H_IDLE;
                        end
                    end
                end
                H_POLL:
                    if (cnt_q != 5'd0)
                        cnt_q <= cnt_q - 5'd1;
                    else if (link.data_out_en && link.data_out)
                    begin
                        // ready seen: deselect floats the status pin
                        cs_q <= 1'b0;
                        prog_q <= 1'b0;
                        cnt_q <= 5'(`SELECT_LOW_MIN_CYC);
                        state_q <= H_GAP;
                    end
                default: state_q <= H_IDLE;
            endcase
        end
    end

    assign link.chip_select = cs_q;
    assign link.serial_clock_in = sk_q;
    assign link.serial_in = di_q;
endmodule

//--- bench/serial_mem_checker.sv
// checker: pin-level timing rules on the serial memory link
// assumes it sits beside the interface and shares the system clock
`timescale 1ns/1ns
module serial_mem_checker
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic chip_select,
    input wire logic serial_clock_in,
    input wire logic serial_in,
    input wire logic data_out,
    input wire logic data_out_en
);
    logic first_q;
    logic first_d;
    logic sk_q;
    default clocking dflt @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    // ****************************************
    // frame tracking
    // ****************************************
    // stays set from deselect until the first serial clock rise
    assign first_d = !chip_select | (first_q & !(serial_clock_in & !sk_q));
    always_ff @(posedge clk)
    begin
        first_q <= reset_n ? first_d : 1'b1;
        sk_q <= reset_n ? serial_clock_in : 1'b0;
    end
    // ****************************************
    // assertions
    // ****************************************
    a_float_when_idle: assert property (
        !chip_select [*3] |-> !data_out_en)
        else $error("output driven while deselected");
    a_cs_low_min: assert property (
        $fell(chip_select) |-> !chip_select [*5])
        else $error("select low time too short");
    a_cs_before_sk: assert property (
        $rose(serial_clock_in) |-> $past(chip_select))
        else $error("serial clock rose without select");
    a_sk_high_min: assert property (
        $rose(serial_clock_in) |-> serial_clock_in [*5])
        else $error("serial clock high too short");
    a_sk_low_min: assert property (
        $fell(serial_clock_in) |-> !serial_clock_in [*5])
        else $error("serial clock low too short");
    a_sk_still_idle: assert property (
        !chip_select && !$past(chip_select) |-> $stable(serial_clock_in))
        else $error("serial clock moved outside a frame");
    a_di_steady: assert property (
        $rose(serial_clock_in) |-> (serial_in == $past(serial_in, 2))
        ##1 $stable(serial_in) [*2])
        else $error("serial input moved near clock rise");
    a_start_bit_one: assert property (
        $rose(serial_clock_in) && first_q |-> serial_in)
        else $error("frame began without a start bit");
    c_frame_end: cover property ($fell(chip_select));
    c_out_high: cover property (data_out_en && data_out);
    c_out_low: cover property (data_out_en && !data_out);
endmodule

//--- bench/serial_mem_bench.sv
// bench: host and memory ends joined, driven through the host requests
// assumes both ends share clk; short program and power-up counts
`timescale 1ns/1ns
`define CHK(got, exp) \
    begin \
        n_checks++; \
        if ((got) !== (exp)) \
        begin \
            errors++; \
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp); \
        end \
    end
module serial_mem_bench
    import serial_mem_pkg::*;
;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic wide = 1'b1;
    logic req_valid = 1'b0;
    mem_cmd_t req_cmd = CMD_READ;
    logic [6:0] req_addr = 7'h00;
    logic [15:0] req_data = 16'h0000;
    logic req_ready;
    logic rsp_valid;
    logic [15:0] rsp_data;
    logic [15:0] mem_m [128];
    logic en_m = 1'b0;
    integer seed = 32'ha243;
    int errors = 0;
    int n_checks = 0;
    serial_mem_if link ();
    serial_mem_host #(.POWERUP_CYCLES(10)) serial_mem_host_i (.clk(clk),
        .reset_n(reset_n), .wide_mode(wide), .req_valid(req_valid),
        .req_cmd(req_cmd), .req_addr(req_addr), .req_data(req_data),
        .req_ready(req_ready), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data), .link(link));
    serial_mem_device #(.PROGRAM_CYCLES(50)) serial_mem_device_i (.clk(clk),
        .reset_n(reset_n), .word_width_strap(wide), .link(link));
    serial_mem_checker serial_mem_checker_i (.clk(clk), .reset_n(reset_n),
        .chip_select(link.chip_select),
        .serial_clock_in(link.serial_clock_in), .serial_in(link.serial_in),
        .data_out(link.data_out), .data_out_en(link.data_out_en));
    always #25 clk = ~clk;
    // ****************************************
    // expectations and request driver
    // ****************************************
    function automatic logic [15:0] dmask();
        return wide ? 16'hffff : 16'h00ff;
    endfunction
    task automatic op(input mem_cmd_t c, input logic [6:0] a,
        input logic [15:0] d);
        int n;
        logic [6:0] ai;
        ai = a & (wide ? 7'h3f : 7'h7f);
        @(negedge clk);
        req_valid = 1'b1;
        req_cmd = c;
        req_addr = ai;
        req_data = d & dmask();
        for (n = 0; n < 4000 && req_ready !== 1'b1; n++)
            @(negedge clk);
        if (n == 4000)
        begin
            errors++;
            $display("CHECK FAILED t=%0t request not taken", $time);
        end
        @(negedge clk);
        req_valid = 1'b0;
        case (c)
            CMD_ENABLE: en_m = 1'b1;
            CMD_DISABLE: en_m = 1'b0;
            CMD_WRITE: if (en_m) mem_m[ai] = d & dmask();
            CMD_ERASE: if (en_m) mem_m[ai] = dmask();
            CMD_CLEAR_ALL: if (en_m) foreach (mem_m[i]) mem_m[i] = dmask();
            CMD_FILL_ALL: if (en_m) foreach (mem_m[i]) mem_m[i] = d & dmask();
            default: ;
        endcase
        if (c == CMD_READ)
        begin
            for (n = 0; n < 4000 && rsp_valid !== 1'b1; n++)
                @(negedge clk);
            if (n == 4000)
            begin
                errors++;
                $display("CHECK FAILED t=%0t no read response", $time);
            end
            `CHK(rsp_data & dmask(), mem_m[ai])
            `CHK(link.data_out_en | link.chip_select, 1'b0)
        end
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // ****************************************
    // main sequence, x16 then x8
    // ****************************************
    initial
    begin
        logic [31:0] k;
        repeat (8) @(negedge clk);
        reset_n = 1'b1;
        for (int m = 0; m < 2; m++)
        begin
            wide = (m == 0);
            repeat (4) @(negedge clk);
            op(CMD_ENABLE, 7'h00, 16'h0000);
            op(CMD_FILL_ALL, 7'h00, $random(seed));
            op(CMD_READ, 7'h7f, 16'h0000);
            op(CMD_DISABLE, 7'h00, 16'h0000);
            op(CMD_WRITE, 7'h00, 16'h0000);
            op(CMD_ERASE, 7'h7f, 16'h0000);
            op(CMD_CLEAR_ALL, 7'h00, 16'h0000);
            op(CMD_READ, 7'h00, 16'h0000);
            op(CMD_ENABLE, 7'h00, 16'h0000);
            op(CMD_WRITE, 7'h7f, 16'h0000);
            op(CMD_READ, 7'h7f, 16'h0000);
            for (int j = 0; j < 12; j++)
            begin
                k = $random(seed);
                op(k[0] ? CMD_READ : (k[1] ? CMD_WRITE : CMD_ERASE),
                    k[8:2], k[31:16]);
                op(CMD_READ, k[8:2], 16'h0000);
            end
            op(CMD_CLEAR_ALL, 7'h00, 16'h0000);
            op(CMD_READ, 7'h15, 16'h0000);
        end
        summarize();
    end
    // a hang counts as a mismatch
    initial
    begin
        #4000000;
        errors++;
        summarize();
    end
endmodule
